// ---- hw/cmb_pkg.sv ----
package cmb_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] ADDR_RX_FLAG = 8'h00;
    localparam logic [7:0] ADDR_RX_IRQ_EN = 8'h01;
    localparam logic [7:0] ADDR_CTRL = 8'h02;
    localparam logic [7:0] ADDR_TX_SEL = 8'h03;
    localparam logic [7:0] ADDR_TX_PRIO = 8'h04;
    localparam logic [7:0] ADDR_TX_EMPTY = 8'h05;
    localparam logic [7:0] ADDR_RX_ID0 = 8'h06;
    localparam logic [7:0] ADDR_RX_ID1 = 8'h07;
    localparam logic [7:0] ADDR_RX_ID2 = 8'h08;
    localparam logic [7:0] ADDR_RX_ID3 = 8'h09;
    localparam logic [7:0] ADDR_RX_DLC = 8'h0A;
    localparam logic [7:0] ADDR_TS_HIGH = 8'h0B;
    localparam logic [7:0] ADDR_TS_LOW = 8'h0C;
    localparam logic [7:0] ADDR_TX_WIN = 8'h0D;
    localparam logic [7:0] ADDR_STATUS = 8'h0E;

    // Field positions.
    localparam int RXF_BIT = 0;
    localparam int OVR_BIT = 1;
    localparam int TSEN_BIT = 0;
    localparam int ID3_RTR_BIT = 0;

    // Reset values.
    localparam logic [7:0] RX_IRQ_EN_RST = 8'h00;
    localparam logic [7:0] TX_PRIO_RST = 8'h00;

    // Error count past which the transmitter goes bus-off.
    localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;

    // Largest valid data length code.
    localparam logic [3:0] DLC_MAX = 4'h8;

    // Receiver state indication codes.
    localparam logic [1:0] RX_STATE_OK = 2'h0;
    localparam logic [1:0] RX_STATE_BUS_OFF = 2'h3;

    // Received frame as delivered by the receive FIFO.
    typedef struct packed {
        logic        ide;
        logic [28:0] id;
        logic        rtr;
        logic [3:0]  dlc;
    } cmb_frame_t;

    // Register bus request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmb_bus_t;

endpackage

// ---- hw/cmb_msg_buffer.sv ----
`timescale 1ns/1ps
// Contract
// - Overrun sets overrun flag; error irq pends while unmasked.
// - Good message into foreground sets full flag.
// - No FIFO shift while full flag set.
// - Receive irq pends while full, unmasked.
// - Bus-off above 255 errors, shown receiver.
// - Leaving bus-off sets receiver state OK.
// - Irq enables held reset in init mode.
// - State select fields survive init mode.
// - 29-bit ids, low bits 7:1 of reg3.
// - 11-bit ids, bits 10:3 in reg0.
// - RTR flag shows frame RTR.
// - Length code is binary byte count.
// - Lowest local priority buffer wins.
// - Non-empty buffers compete before start.
// - Ties go to lower buffer index.
// - Priority accessible only when empty, selected.
// - Time stamp written on acknowledge.
module cmb_msg_buffer #(
    parameter int NUM_TX = 3,
    parameter int PRIO_W = 8
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port.
    input wire cmb_pkg::cmb_bus_t bus,
    output logic [7:0] rdata,
    // Receive FIFO side.
    input wire logic fifo_valid,
    input wire cmb_pkg::cmb_frame_t fifo_frame,
    output logic fifo_pop,
    input wire logic rx_overrun,
    // Controller status.
    input wire logic init_request,
    input wire logic init_ack,
    input wire logic [8:0] tx_err_count,
    input wire logic [15:0] timer_value,
    input wire logic msg_acked,
    // Transmit side.
    input wire logic [NUM_TX-1:0] tx_buffer_empty_flag,
    input wire logic sof_pending,
    output logic [NUM_TX-1:0] tx_winner,
    output logic [NUM_TX-1:0] tx_ts_strobe,
    // Interrupt requests and status.
    output logic rx_irq,
    output logic err_irq,
    output logic bus_off,
    output logic [1:0] rx_state
);

    ////////////////////////////////////////////////////////////////////////
    // State record.

    // All state of the block lives in one packed record.
    typedef struct packed {
        // Two-stage reset release synchroniser.
        logic [1:0] rst_sync;
        // Foreground buffer holds an unread message.
        logic rx_full_flag;
        // A receive overrun has been seen since the last clear.
        logic overrun_flag;
        // Receive interrupt enables, bit 0 full, bit 1 overrun.
        logic [7:0] rx_irq_enable_reg;
        // Receiver state interrupt selection, kept through init.
        logic [1:0] rx_state_irq_select;
        // Transmitter state interrupt selection, kept through init.
        logic [1:0] tx_state_irq_select;
        // Stamp acknowledged messages when set.
        logic timestamp_enable;
        // Software choice of transmit buffer for the priority window.
        logic [NUM_TX-1:0] tx_buffer_select;
        // Local arbitration priority of each transmit buffer.
        logic [NUM_TX-1:0][PRIO_W-1:0] tx_local_priority;
        // Message currently offered to software.
        cmb_pkg::cmb_frame_t rx_foreground_buffer;
        // Timer value captured at the last acknowledge.
        logic [15:0] timestamp;
        // One-hot result of the last arbitration.
        logic [NUM_TX-1:0] tx_winner;
        // One-cycle pulse naming the buffer that was stamped.
        logic [NUM_TX-1:0] tx_ts_strobe;
        // Read data, valid for one cycle after a read strobe.
        logic [7:0] rdata;
        // One-cycle pulse taking the FIFO head.
        logic fifo_pop;
        // Receive interrupt request.
        logic rx_irq;
        // Error interrupt request.
        logic err_irq;
        // Transmitter is bus-off.
        logic bus_off;
        // Receiver state indication.
        logic [1:0] rx_state;
    } cmb_state_t;

    cmb_state_t st_reg;
    cmb_state_t st_next;

    // Released reset for the body.
    logic rst_ok;
    assign rst_ok = st_reg.rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Length code as a byte count; illegal codes saturate at eight.
    function automatic logic [3:0] dlc_count(input logic [3:0] code);
        dlc_count = (code > cmb_pkg::DLC_MAX) ? cmb_pkg::DLC_MAX : code;
    endfunction

    // Identifier register image, standard or extended layout.
    function automatic logic [7:0] id_reg(input cmb_pkg::cmb_frame_t f,
                                          input logic [1:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (f.ide) begin
            unique case (idx)
                // Identifier bits 28 to 21.
                2'd0: v = f.id[28:21];
                // Bits 20 to 18, the two fixed ones, bits 17 to 15.
                2'd1: v = {f.id[20:18], 1'b1, 1'b1, f.id[17:15]};
                // Identifier bits 14 to 7.
                2'd2: v = f.id[14:7];
                // Low seven identifier bits above the remote flag.
                2'd3: v = {f.id[6:0], f.rtr};
            endcase
        end else begin
            unique case (idx)
                // Identifier bits 10 to 3.
                2'd0: v = f.id[10:3];
                // Low three identifier bits, remote flag, format bit.
                2'd1: v = {f.id[2:0], f.rtr, 1'b0, 3'b000};
                // No further identifier bits in the standard layout.
                2'd2: v = 8'h00;
                // Unused in the standard layout.
                2'd3: v = 8'h00;
            endcase
        end
        id_reg = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Computes every register's next value from the current record.
    always_comb begin
        // Both init handshake bits high: initialisation mode.
        logic init_mode;
        // Both init handshake bits low: normal running.
        logic run_mode;
        // Software asks to clear the full flag this cycle.
        logic clr_rxf;
        // Software asks to clear the overrun flag this cycle.
        logic clr_ovr;
        // Lowest local priority seen so far in arbitration.
        logic [PRIO_W-1:0] best;
        // A selected empty buffer owns the priority window.
        logic found;
        // At least one filled buffer has entered arbitration.
        logic any_full;
        // One-hot arbitration result.
        logic [NUM_TX-1:0] win;
        // Index of the buffer behind the priority window.
        int sel;
        init_mode = 1'b0;
        run_mode = 1'b0;
        clr_rxf = 1'b0;
        clr_ovr = 1'b0;
        best = '0;
        found = 1'b0;
        any_full = 1'b0;
        win = '0;
        sel = 0;
        // Every register keeps its value unless a branch below moves it.
        st_next = st_reg;
        // The reset synchroniser shifts in ones after release.
        st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
        // Decode the init handshake into its two stable modes.
        init_mode = init_request & init_ack;
        run_mode = ~init_request & ~init_ack;
        // Pulses and read data fall back to zero each cycle.
        st_next.fifo_pop = 1'b0;
        st_next.rdata = 8'h00;
        st_next.tx_ts_strobe = '0;

        // Write one clears a receive flag.
        if (bus.wr && bus.addr == cmb_pkg::ADDR_RX_FLAG) begin
            clr_rxf = bus.wdata[cmb_pkg::RXF_BIT];
            clr_ovr = bus.wdata[cmb_pkg::OVR_BIT];
        end
        // Hardware set wins over a software clear in the same cycle.
        st_next.overrun_flag = rx_overrun |
                               (st_reg.overrun_flag & ~clr_ovr);
        if (clr_rxf) begin
            st_next.rx_full_flag = 1'b0;
        end
        // Shift only into a released foreground buffer.
        if (fifo_valid && !st_reg.rx_full_flag) begin
            st_next.rx_foreground_buffer = fifo_frame;
            st_next.rx_full_flag = 1'b1;
            st_next.fifo_pop = 1'b1;
        end

        // Enables held at reset value in init mode.
        if (init_mode) begin
            st_next.rx_irq_enable_reg = cmb_pkg::RX_IRQ_EN_RST;
        end else if (run_mode && bus.wr &&
                     bus.addr == cmb_pkg::ADDR_RX_IRQ_EN) begin
            st_next.rx_irq_enable_reg = bus.wdata;
        end
        // Select fields ignore init mode; they follow their own writes.
        if (bus.wr && bus.addr == cmb_pkg::ADDR_STATUS) begin
            st_next.rx_state_irq_select = bus.wdata[5:4];
            st_next.tx_state_irq_select = bus.wdata[3:2];
        end
        if (bus.wr && bus.addr == cmb_pkg::ADDR_CTRL) begin
            st_next.timestamp_enable = bus.wdata[cmb_pkg::TSEN_BIT];
        end
        if (bus.wr && bus.addr == cmb_pkg::ADDR_TX_SEL) begin
            st_next.tx_buffer_select = bus.wdata[NUM_TX-1:0];
        end

        // Lowest selected empty buffer owns the priority window.
        for (int i = NUM_TX - 1; i >= 0; i--) begin
            if (st_reg.tx_buffer_select[i] && tx_buffer_empty_flag[i]) begin
                sel = i;
                found = 1'b1;
            end
        end
        if (bus.wr && bus.addr == cmb_pkg::ADDR_TX_PRIO && found) begin
            st_next.tx_local_priority[sel] = bus.wdata[PRIO_W-1:0];
        end

        // Internal arbitration just before start of frame.
        // The first filled buffer seeds the search; later ones must
        // beat it strictly, so a tie keeps the lower index.
        best = '1;
        any_full = 1'b0;
        for (int i = 0; i < NUM_TX; i++) begin
            // Only buffers that hold a message take part.
            if (!tx_buffer_empty_flag[i] &&
                (!any_full ||
                 st_reg.tx_local_priority[i] < best)) begin
                best = st_reg.tx_local_priority[i];
                win = '0;
                win[i] = 1'b1;
                any_full = 1'b1;
            end
        end
        // The winner is latched only on the arbitration strobe.
        if (sof_pending) begin
            st_next.tx_winner = win;
        end

        // Stamp the active buffer once acknowledged.
        if (st_reg.timestamp_enable && msg_acked) begin
            st_next.timestamp = timer_value;
            st_next.tx_ts_strobe = st_reg.tx_winner;
        end

        // Bus-off and receiver state indication.
        st_next.bus_off = (tx_err_count > cmb_pkg::BUS_OFF_LIMIT);
        // The receiver shows OK again in the same cycle bus-off ends.
        st_next.rx_state = st_next.bus_off ? cmb_pkg::RX_STATE_BUS_OFF
                                           : cmb_pkg::RX_STATE_OK;

        // Interrupt requests from flags and enables.
        st_next.rx_irq = st_next.rx_full_flag &
            st_next.rx_irq_enable_reg[cmb_pkg::RXF_BIT];
        st_next.err_irq = st_next.overrun_flag &
            st_next.rx_irq_enable_reg[cmb_pkg::OVR_BIT];

        // Read data for the cycle after the strobe.
        if (bus.rd) begin
            unique case (bus.addr)
                // Receive flags: bit 1 overrun, bit 0 full.
                cmb_pkg::ADDR_RX_FLAG:
                    st_next.rdata = {6'h00, st_reg.overrun_flag,
                                     st_reg.rx_full_flag};
                // Interrupt enables, readable at any time.
                cmb_pkg::ADDR_RX_IRQ_EN:
                    st_next.rdata = st_reg.rx_irq_enable_reg;
                // Control: time stamp enable.
                cmb_pkg::ADDR_CTRL:
                    st_next.rdata = {7'h00, st_reg.timestamp_enable};
                // Transmit buffer selection.
                cmb_pkg::ADDR_TX_SEL:
                    st_next.rdata = 8'(st_reg.tx_buffer_select);
                // Priority window; reads zero when no buffer is open.
                cmb_pkg::ADDR_TX_PRIO:
                    st_next.rdata = found ? 8'(st_reg.tx_local_priority[sel])
                                          : 8'h00;
                // Transmit empty flags as seen from the controller.
                cmb_pkg::ADDR_TX_EMPTY:
                    st_next.rdata = 8'(tx_buffer_empty_flag);
                // First identifier register of the foreground message.
                cmb_pkg::ADDR_RX_ID0:
                    st_next.rdata = id_reg(st_reg.rx_foreground_buffer, 2'd0);
                // Second identifier register.
                cmb_pkg::ADDR_RX_ID1:
                    st_next.rdata = id_reg(st_reg.rx_foreground_buffer, 2'd1);
                // Third identifier register.
                cmb_pkg::ADDR_RX_ID2:
                    st_next.rdata = id_reg(st_reg.rx_foreground_buffer, 2'd2);
                // Fourth identifier register.
                cmb_pkg::ADDR_RX_ID3:
                    st_next.rdata = id_reg(st_reg.rx_foreground_buffer, 2'd3);
                // Byte count of the foreground message.
                cmb_pkg::ADDR_RX_DLC:
                    st_next.rdata = {4'h0,
                        dlc_count(st_reg.rx_foreground_buffer.dlc)};
                // Upper half of the last time stamp.
                cmb_pkg::ADDR_TS_HIGH:
                    st_next.rdata = st_reg.timestamp[15:8];
                // Lower half of the last time stamp.
                cmb_pkg::ADDR_TS_LOW:
                    st_next.rdata = st_reg.timestamp[7:0];
                // Last arbitration winner.
                cmb_pkg::ADDR_TX_WIN:
                    st_next.rdata = 8'(st_reg.tx_winner);
                // State selection fields and receiver state.
                cmb_pkg::ADDR_STATUS:
                    st_next.rdata = {2'b00, st_reg.rx_state_irq_select,
                                     st_reg.tx_state_irq_select,
                                     st_reg.rx_state};
                // Unmapped addresses read as zero.
                default:
                    st_next.rdata = 8'h00;
            endcase
        end

        // Hold everything but the synchroniser until reset is released.
        if (!rst_ok) begin
            st_next = '0;
            st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    // Registers the record; asynchronous reset loads all zeros.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // Asynchronous reset clears the whole record.
            st_reg <= '0;
        end else begin
            // Otherwise take the computed next state.
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the record.
    // Read data of the previous read strobe.
    assign rdata = st_reg.rdata;
    // Pulse taking the FIFO head.
    assign fifo_pop = st_reg.fifo_pop;
    // Arbitration result.
    assign tx_winner = st_reg.tx_winner;
    // Stamp pulse for the winning buffer.
    assign tx_ts_strobe = st_reg.tx_ts_strobe;
    // Receive interrupt request.
    assign rx_irq = st_reg.rx_irq;
    // Error interrupt request.
    assign err_irq = st_reg.err_irq;
    // Bus-off status.
    assign bus_off = st_reg.bus_off;
    // Receiver state indication.
    assign rx_state = st_reg.rx_state;

endmodule

// ---- sim/cmb_msg_buffer_properties.sv ----
`timescale 1ns/1ps
// Port-level checks on the message buffer.
module cmb_chk #(
    parameter int NUM_TX = 3,
    parameter int PRIO_W = 8
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port.
    input wire cmb_pkg::cmb_bus_t bus,
    input wire logic [7:0] rdata,
    // Receive and status side.
    input wire logic fifo_pop,
    input wire logic rx_overrun,
    input wire logic init_request,
    input wire logic init_ack,
    input wire logic [8:0] tx_err_count,
    input wire logic bus_off,
    input wire logic [1:0] rx_state,
    // Transmit side.
    input wire logic msg_acked,
    input wire logic [NUM_TX-1:0] tx_buffer_empty_flag,
    input wire logic sof_pending,
    input wire logic [NUM_TX-1:0] tx_winner,
    input wire logic [NUM_TX-1:0] tx_ts_strobe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Enable write, then enable read, both in initialisation mode.
    sequence en_wr_s;
        bus.wr && bus.addr == cmb_pkg::ADDR_RX_IRQ_EN &&
            init_request && init_ack;
    endsequence
    sequence en_rd_s;
        bus.rd && bus.addr == cmb_pkg::ADDR_RX_IRQ_EN &&
            init_request && init_ack;
    endsequence
    en_hold_a: assert property (en_wr_s ##[1:2] en_rd_s |=>
        rdata == 8'h00)
        else $error("enable register changed in init mode");
    ovr_set_a: assert property (rx_overrun && !bus.wr ##1 !bus.wr ##1
        bus.rd && bus.addr == cmb_pkg::ADDR_RX_FLAG |=> rdata[1])
        else $error("overrun flag not set");
    pop_once_a: assert property (fifo_pop |=> !fifo_pop)
        else $error("second shift while buffer full");
    boff_hi_a: assert property ((tx_err_count > 9'h0FF) [*2] |-> bus_off)
        else $error("bus-off missing above limit");
    boff_lo_a: assert property ((tx_err_count <= 9'h0FF) [*2] |->
        !bus_off)
        else $error("bus-off without count above limit");
    rx_state_a: assert property (rx_state == (bus_off ? 2'h3 : 2'h0))
        else $error("receiver state disagrees with bus-off");
    win_part_a: assert property (sof_pending |=>
        (tx_winner & $past(tx_buffer_empty_flag)) == '0 &&
        ((tx_winner == '0) == (&$past(tx_buffer_empty_flag))))
        else $error("winner not taken from filled buffers");
    stamp_ack_a: assert property (tx_ts_strobe != '0 |->
        $past(msg_acked) && (tx_ts_strobe & ~tx_winner) == '0)
        else $error("stamp without acknowledge or off winner");
endmodule
bind cmb_msg_buffer cmb_chk #(.NUM_TX(NUM_TX), .PRIO_W(PRIO_W)) chk_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .fifo_pop(fifo_pop), .rx_overrun(rx_overrun),
    .init_request(init_request), .init_ack(init_ack),
    .tx_err_count(tx_err_count), .bus_off(bus_off), .rx_state(rx_state),
    .msg_acked(msg_acked), .tx_buffer_empty_flag(tx_buffer_empty_flag),
    .sof_pending(sof_pending), .tx_winner(tx_winner),
    .tx_ts_strobe(tx_ts_strobe));

// ---- sim/cmb_rx_src.sv ----
`timescale 1ns/1ps
// Receive FIFO holding good frames from the bus.
module cmb_rx_src (
    // Clock and bench load.
    input wire logic clk_sys,
    input wire logic load,
    input wire cmb_pkg::cmb_frame_t load_frame,
    // Buffer side.
    input wire logic fifo_pop,
    output logic fifo_valid = 1'b0,
    output cmb_pkg::cmb_frame_t fifo_frame = '1
);
    cmb_pkg::cmb_frame_t q[$];
    cmb_pkg::cmb_frame_t last = '0;
    // Head stays offered until popped; idle lines carry junk, not old data.
    always @(posedge clk_sys) begin
        if (fifo_pop && q.size() != 0) begin
            last = q.pop_front();
        end
        if (load) begin
            q.push_back(load_frame);
        end
        fifo_valid <= q.size() != 0;
        fifo_frame <= (q.size() != 0) ? q[0] : ~last;
    end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the message buffer.
module tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    cmb_pkg::cmb_bus_t bus = '0;
    logic rx_overrun = 1'b0, init_request = 1'b0, init_ack = 1'b0;
    logic msg_acked = 1'b0, sof_pending = 1'b0, load = 1'b0;
    logic [8:0] tx_err_count = 9'h000;
    logic [2:0] tx_buffer_empty_flag = 3'h7;
    cmb_pkg::cmb_frame_t load_frame = '0, f1, f2, fifo_frame;
    logic [7:0] rdata;
    logic fifo_valid, fifo_pop, rx_irq, err_irq, bus_off;
    logic [2:0] tx_winner, tx_ts_strobe;
    logic [1:0] rx_state;
    int err_count = 0, total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    cmb_msg_buffer dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus),
        .rdata(rdata), .fifo_valid(fifo_valid), .fifo_frame(fifo_frame),
        .fifo_pop(fifo_pop), .rx_overrun(rx_overrun),
        .init_request(init_request), .init_ack(init_ack),
        .tx_err_count(tx_err_count), .timer_value(16'h1234),
        .msg_acked(msg_acked), .tx_buffer_empty_flag(tx_buffer_empty_flag),
        .sof_pending(sof_pending), .tx_winner(tx_winner),
        .tx_ts_strobe(tx_ts_strobe), .rx_irq(rx_irq), .err_irq(err_irq),
        .bus_off(bus_off), .rx_state(rx_state));
    cmb_rx_src src (.clk_sys(clk_sys), .load(load), .load_frame(load_frame),
        .fifo_pop(fifo_pop), .fifo_valid(fifo_valid),
        .fifo_frame(fifo_frame));
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One-cycle bus strobes; reads judge the data of the following cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string n);
        @(posedge clk_sys);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        bus <= '0;
        #1;
        chk(n, e, rdata);
    endtask
    // The pop pulse stands one cycle; look just after each edge.
    task automatic wait_pop();
        int n;
        n = 0;
        #1;
        while (fifo_pop !== 1'b1 && n <= 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (fifo_pop !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
    endtask
    task automatic t_init();
        wr(cmb_pkg::ADDR_RX_IRQ_EN, 8'h03);
        wr(cmb_pkg::ADDR_STATUS, 8'h3C);
        @(posedge clk_sys);
        init_request <= 1'b1;
        init_ack <= 1'b1;
        rd(cmb_pkg::ADDR_RX_IRQ_EN, 8'h00, "en");
        wr(cmb_pkg::ADDR_RX_IRQ_EN, 8'h03);
        rd(cmb_pkg::ADDR_RX_IRQ_EN, 8'h00, "en");
        rd(cmb_pkg::ADDR_STATUS, 8'h3C, "sel");
        @(posedge clk_sys);
        init_request <= 1'b0;
        init_ack <= 1'b0;
        wr(cmb_pkg::ADDR_RX_IRQ_EN, 8'h03);
        rd(cmb_pkg::ADDR_RX_IRQ_EN, 8'h03, "en");
        rd(8'h20, 8'h00, "unmapped");
    endtask
    task automatic t_rx();
        f1 = '{1'b1, 29'h1ABC_DE5B, 1'b1, 4'h5};
        f2 = '{1'b0, 29'h0000_05A3, 1'b0, 4'h8};
        @(posedge clk_sys);
        load <= 1'b1;
        load_frame <= f1;
        @(posedge clk_sys);
        load_frame <= f2;
        @(posedge clk_sys);
        load <= 1'b0;
        wait_pop();
        repeat (2) @(posedge clk_sys);
        #1;
        chk("rx_irq", 8'h01, {7'h00, rx_irq});
        rd(cmb_pkg::ADDR_RX_FLAG, 8'h01, "flags");
        rd(cmb_pkg::ADDR_RX_ID3, {f1.id[6:0], f1.rtr}, "id3");
        rd(cmb_pkg::ADDR_RX_DLC, 8'h05, "dlc");
        wr(cmb_pkg::ADDR_RX_FLAG, 8'h00);
        rd(cmb_pkg::ADDR_RX_FLAG, 8'h01, "flags");
        wr(cmb_pkg::ADDR_RX_FLAG, 8'h01);
        wait_pop();
        rd(cmb_pkg::ADDR_RX_ID0, f2.id[10:3], "id0");
        rd(cmb_pkg::ADDR_RX_DLC, 8'h08, "dlc");
        wr(cmb_pkg::ADDR_RX_FLAG, 8'h01);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("rx_irq", 8'h00, {7'h00, rx_irq});
    endtask
    task automatic t_ovr();
        @(posedge clk_sys);
        rx_overrun <= 1'b1;
        @(posedge clk_sys);
        rx_overrun <= 1'b0;
        rd(cmb_pkg::ADDR_RX_FLAG, 8'h02, "flags");
        chk("err_irq", 8'h01, {7'h00, err_irq});
        wr(cmb_pkg::ADDR_RX_FLAG, 8'h02);
        rd(cmb_pkg::ADDR_RX_FLAG, 8'h00, "flags");
        chk("err_irq", 8'h00, {7'h00, err_irq});
    endtask
    task automatic t_boff();
        logic [8:0] c [3] = '{9'h0FF, 9'h100, 9'h000};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            tx_err_count <= c[i];
            repeat (3) @(posedge clk_sys);
            #1;
            chk("bus_off", {7'h00, i == 1}, {7'h00, bus_off});
            chk("rx_state", (i == 1) ? 8'h03 : 8'h00, {6'h00, rx_state});
        end
    endtask
    task automatic sof(input logic [2:0] e);
        @(posedge clk_sys);
        sof_pending <= 1'b1;
        @(posedge clk_sys);
        sof_pending <= 1'b0;
        #1;
        chk("winner", {5'h00, e}, {5'h00, tx_winner});
    endtask
    task automatic ack(input logic [2:0] e);
        @(posedge clk_sys);
        msg_acked <= 1'b1;
        @(posedge clk_sys);
        msg_acked <= 1'b0;
        #1;
        chk("stamp", {5'h00, e}, {5'h00, tx_ts_strobe});
    endtask
    task automatic t_prio();
        logic [7:0] pr [3] = '{8'h05, 8'h30, 8'h30};
        for (int i = 0; i < 3; i++) begin
            wr(cmb_pkg::ADDR_TX_SEL, 8'h01 << i);
            wr(cmb_pkg::ADDR_TX_PRIO, pr[i]);
        end
        rd(cmb_pkg::ADDR_TX_PRIO, 8'h30, "prio");
        tx_buffer_empty_flag <= 3'h1;
        sof(3'h2);
        tx_buffer_empty_flag <= 3'h7;
        wr(cmb_pkg::ADDR_TX_PRIO, 8'h20);
        tx_buffer_empty_flag <= 3'h1;
        sof(3'h4);
        wr(cmb_pkg::ADDR_TX_SEL, 8'h02);
        rd(cmb_pkg::ADDR_TX_PRIO, 8'h00, "prio");
        ack(3'h0);
        wr(cmb_pkg::ADDR_CTRL, 8'h01);
        ack(3'h4);
        rd(cmb_pkg::ADDR_TX_WIN, 8'h04, "win");
        rd(cmb_pkg::ADDR_TS_HIGH, 8'h12, "ts_high");
        rd(cmb_pkg::ADDR_TS_LOW, 8'h34, "ts_low");
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_init();
        t_rx();
        t_ovr();
        t_boff();
        t_prio();
        report_and_stop();
    end
endmodule
